// ==== core/scc_defs.vh ====
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// instruction field positions
`define SCC_DIR_BIT 20
`define SCC_REG_HI 19
`define SCC_REG_LO 16
`define SCC_CORE_HI 15
`define SCC_CORE_LO 12
`define SCC_CPN_HI 11
`define SCC_CPN_LO 8
`define SCC_OP_HI 7
`define SCC_OP_LO 5
`define SCC_MARK_BIT 4
`define SCC_SUB_HI 3
`define SCC_SUB_LO 0
`define SCC_CLASS_HI 27
`define SCC_CLASS_LO 24

// fixed instruction codes
`define SCC_CLASS_CODE 4'hE
`define SCC_CPN_CODE 4'hF
`define SCC_DIR_READ 1'b1

// register selects
`define SCC_SEL_IDENT 4'h0
`define SCC_SEL_CTRL 4'h1
`define SCC_SEL_TBASE 4'h2
`define SCC_SEL_CACHE 4'h7
`define SCC_SEL_TLB 4'h8
`define SCC_SEL_RBUF 4'h9
`define SCC_SEL_PTAG 4'hD
`define SCC_SEL_BRK 4'hE
`define SCC_SEL_TEST 4'hF

// read-buffer user access control codes
`define SCC_RB_SUB_CTL 4'h0
`define SCC_RB_OP_USER_ON 3'h5
`define SCC_RB_OP_USER_OFF 3'h4

// system control bit positions
`define SCC_CTL_MMU 0
`define SCC_CTL_ALIGN 1
`define SCC_CTL_DCACHE 2
`define SCC_CTL_WBUF 3
`define SCC_CTL_FIX_LO 4
`define SCC_CTL_FIX_HI 6
`define SCC_CTL_ENDIAN 7
`define SCC_CTL_SYSP 8
`define SCC_CTL_ROMP 9
`define SCC_CTL_ICACHE 12
`define SCC_CTL_HIVEC 13

// translation table base field
`define SCC_TBASE_LO 14
`define SCC_TBASE_W 18

// reset values and fixed patterns
`define SCC_CTL_RESET 1'b0
`define SCC_CTL_FIXED 3'h7
`define SCC_WORD_ZERO 32'h00000000
`define SCC_TBASE_RESET 18'h00000
`define SCC_VEC_LOW 32'h00000000
`define SCC_VEC_HIGH 32'hFFFF0000

`endif

// ==== core/scc_decode.v ====
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.vh"

module scc_decode (
  input wire [31:0] instr_word,
  input wire core_priv,
  input wire user_rbuf_en,
  output wire is_ours,
  output wire is_read,
  output wire [3:0] reg_sel,
  output wire [3:0] core_reg,
  output wire [2:0] op_field,
  output wire [3:0] subop_field,
  output wire allowed
);

  assign reg_sel = instr_word[`SCC_REG_HI:`SCC_REG_LO]; // RL23
  assign core_reg = instr_word[`SCC_CORE_HI:`SCC_CORE_LO]; // RL23
  assign op_field = instr_word[`SCC_OP_HI:`SCC_OP_LO]; // RL23
  assign subop_field = instr_word[`SCC_SUB_HI:`SCC_SUB_LO]; // RL23
  assign is_read = (instr_word[`SCC_DIR_BIT] == `SCC_DIR_READ); // RL3

  // only register transfers to this coprocessor are claimed
  assign is_ours = (instr_word[`SCC_CLASS_HI:`SCC_CLASS_LO] == `SCC_CLASS_CODE) &&
                   (instr_word[`SCC_CPN_HI:`SCC_CPN_LO] == `SCC_CPN_CODE) &&
                   instr_word[`SCC_MARK_BIT]; // RL23

  // user mode may only write the read-buffer select once enabled; a drain
  // of the write buffer sits on the cache select and so still traps
  assign allowed = core_priv ||
                   (user_rbuf_en && !is_read && (reg_sel == `SCC_SEL_RBUF)); // RL1 RL21

endmodule // scc_decode

`default_nettype wire

// ==== core/scc_coproc.v ====
// Functional notes
// RL1: transfers accepted only in privileged mode, except enabled user read-buffer operations.
// RL2: disallowed user-mode access raises the undefined instruction trap, no access done.
// RL3: direction bit one reads a coprocessor register, zero writes one.
// RL4: unimplemented register selects give unpredictable results; here reads zero, writes only load maint_op, maint_subop, maint_data and rd_core_reg.
// RL5: select 0 is read-only identification word; writes are reserved.
// RL6: selects 7, 8, 9, 15 write-only operations; their reads are reserved.
// RL7: selects 13 and 14 are read/write process tag and breakpoint.
// RL8: reset clears every writable system control bit.
// RL9: software always writes ones to system control bits 4, 5, 6.
// RL10: system control bit 0 enables the memory management unit.
// RL11: system control bit 1 enables alignment fault checking.
// RL12: system control bit 2 enables the data cache.
// RL13: system control bit 3 enables the write buffer.
// RL14: system control bit 7 selects big-endian when set.
// RL15: system control bits 8 and 9 modify memory protection checks.
// RL16: system control bit 12 enables the instruction cache.
// RL17: system control bit 13 moves vectors to the high address.
// RL18: system control bits 11:10 and 31:14 ignore writes, read undefined.
// RL19: table base keeps bits 31:14; bits 13:0 ignored on write.
// RL20: software programs reserved fields to zero.
// RL21: user-mode write-buffer drain traps even with read-buffer access enabled.
// RL22: select 9, sub-op 0: op 5 enables, op 4 disables user access.
// RL23: fields: select 19:16, core reg 15:12, cp 11:8, op 7:5, sub-op 3:0.
// RL24: system control reads always return ones in bits 4, 5, 6.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.vh"

module scc_coproc #(
  parameter [7:0] IMPL_CODE = 8'h5A,
  parameter [7:0] ARCH_CODE = 8'h02,
  parameter [11:0] PART_CODE = 12'h3C7,
  parameter [3:0] STEP_CODE = 4'h2
) (
  input wire sys_clk,
  input wire resetn,
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire core_priv,
  input wire [31:0] wr_data,
  output wire instr_ready,
  output reg xfer_done,
  output reg undef_trap,
  output reg [31:0] rd_data,
  output reg [3:0] rd_core_reg,
  output reg mmu_enable,
  output reg align_fault_enable,
  output reg dcache_enable,
  output reg wbuf_enable,
  output reg big_endian,
  output reg sys_protect,
  output reg rom_protect,
  output reg icache_enable,
  output reg high_vectors,
  output wire [31:0] vector_base,
  output reg [31:0] table_base,
  output reg [31:0] process_tag,
  output reg [31:0] breakpoint_cfg,
  output reg user_rbuf_enable,
  output reg cache_op_valid,
  output reg tlb_op_valid,
  output reg rbuf_op_valid,
  output reg test_op_valid,
  output reg [2:0] maint_op,
  output reg [3:0] maint_subop,
  output reg [31:0] maint_data
);

  // the identification fields are arbitrary values, not a real part
  localparam [31:0] IDENT_WORD = {IMPL_CODE, ARCH_CODE, PART_CODE, STEP_CODE};

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_DONE = 3'h2;
  localparam [2:0] ST_TRAP = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  wire is_ours;
  wire is_read;
  wire [3:0] reg_sel;
  wire [3:0] core_reg;
  wire [2:0] op_field;
  wire [3:0] subop_field;
  wire allowed;

  scc_decode u_decode (
    .instr_word(instr_word),
    .core_priv(core_priv),
    .user_rbuf_en(user_rbuf_enable),
    .is_ours(is_ours),
    .is_read(is_read),
    .reg_sel(reg_sel),
    .core_reg(core_reg),
    .op_field(op_field),
    .subop_field(subop_field),
    .allowed(allowed)
  );

  reg [2:0] state;
  reg [2:0] next_state;

  // one transfer in flight: the answer cycle refuses a new request
  assign instr_ready = (state == ST_IDLE);

  wire take = instr_valid && instr_ready && is_ours;
  wire do_access = take && allowed; // RL1
  wire do_write = do_access && !is_read; // RL3
  wire do_read = do_access && is_read; // RL3

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && allowed) begin
          next_state = ST_DONE;
        end else if (take) begin
          next_state = ST_TRAP; // RL2
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      ST_TRAP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      xfer_done <= 1'b0;
      undef_trap <= 1'b0;
      rd_core_reg <= 4'h0;
    end else begin
      state <= next_state;
      xfer_done <= take && allowed;
      // a trapped access leaves every register and operation untouched except rd_core_reg
      undef_trap <= take && !allowed; // RL2
      if (take) begin
        rd_core_reg <= core_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  wire [31:0] ctrl_word = {18'h00000, high_vectors, icache_enable, 2'h0,
                           rom_protect, sys_protect, big_endian, `SCC_CTL_FIXED,
                           wbuf_enable, dcache_enable, align_fault_enable,
                           mmu_enable}; // RL18 RL24

  reg [31:0] next_rd_data;

  always @* begin
    next_rd_data = `SCC_WORD_ZERO;
    case (reg_sel)
      `SCC_SEL_IDENT: begin
        next_rd_data = IDENT_WORD; // RL5
      end
      `SCC_SEL_CTRL: begin
        next_rd_data = ctrl_word;
      end
      `SCC_SEL_TBASE: begin
        next_rd_data = table_base; // RL19
      end
      `SCC_SEL_PTAG: begin
        next_rd_data = process_tag; // RL7
      end
      `SCC_SEL_BRK: begin
        next_rd_data = breakpoint_cfg; // RL7
      end
      default: begin
        // write-only and unimplemented selects answer zero
        next_rd_data = `SCC_WORD_ZERO; // RL4 RL6
      end
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= `SCC_WORD_ZERO;
    end else if (do_read) begin
      rd_data <= next_rd_data; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // system control and table base

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mmu_enable <= `SCC_CTL_RESET; // RL8
      align_fault_enable <= `SCC_CTL_RESET; // RL8
      dcache_enable <= `SCC_CTL_RESET; // RL8
      wbuf_enable <= `SCC_CTL_RESET; // RL8
      big_endian <= `SCC_CTL_RESET; // RL8
      sys_protect <= `SCC_CTL_RESET; // RL8
      rom_protect <= `SCC_CTL_RESET; // RL8
      icache_enable <= `SCC_CTL_RESET; // RL8
      high_vectors <= `SCC_CTL_RESET; // RL8
    end else if (do_write && (reg_sel == `SCC_SEL_CTRL)) begin
      // bits 4..6, 10, 11 and 14 up are not stored at all
      mmu_enable <= wr_data[`SCC_CTL_MMU]; // RL10
      align_fault_enable <= wr_data[`SCC_CTL_ALIGN]; // RL11
      dcache_enable <= wr_data[`SCC_CTL_DCACHE]; // RL12
      wbuf_enable <= wr_data[`SCC_CTL_WBUF]; // RL13
      big_endian <= wr_data[`SCC_CTL_ENDIAN]; // RL14
      sys_protect <= wr_data[`SCC_CTL_SYSP]; // RL15
      rom_protect <= wr_data[`SCC_CTL_ROMP]; // RL15
      icache_enable <= wr_data[`SCC_CTL_ICACHE]; // RL16
      high_vectors <= wr_data[`SCC_CTL_HIVEC]; // RL17
    end
  end

  assign vector_base = high_vectors ? `SCC_VEC_HIGH : `SCC_VEC_LOW; // RL17

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      table_base <= `SCC_WORD_ZERO;
    end else if (do_write && (reg_sel == `SCC_SEL_TBASE)) begin
      // low bits kept at zero so the output is a clean aligned base
      table_base <= {wr_data[31:`SCC_TBASE_LO], 14'h0000}; // RL19
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // process tag and breakpoint

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      process_tag <= `SCC_WORD_ZERO;
      breakpoint_cfg <= `SCC_WORD_ZERO;
    end else begin
      if (do_write && (reg_sel == `SCC_SEL_PTAG)) begin
        process_tag <= wr_data; // RL7
      end
      if (do_write && (reg_sel == `SCC_SEL_BRK)) begin
        breakpoint_cfg <= wr_data; // RL7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // user access to the read buffer

  wire rb_ctl = do_write && (reg_sel == `SCC_SEL_RBUF) &&
                (subop_field == `SCC_RB_SUB_CTL);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      user_rbuf_enable <= 1'b0;
    end else if (rb_ctl && (op_field == `SCC_RB_OP_USER_ON)) begin
      user_rbuf_enable <= 1'b1; // RL22
    end else if (rb_ctl && (op_field == `SCC_RB_OP_USER_OFF)) begin
      user_rbuf_enable <= 1'b0; // RL22
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // maintenance operations

  // the unit that carries out an operation gets one strobe with its fields;
  // decoding of op and sub-op codes stays with that unit, except select 9 sub-op 0 user access control, decoded here
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cache_op_valid <= 1'b0;
      tlb_op_valid <= 1'b0;
      rbuf_op_valid <= 1'b0;
      test_op_valid <= 1'b0;
      maint_op <= 3'h0;
      maint_subop <= 4'h0;
      maint_data <= `SCC_WORD_ZERO;
    end else begin
      cache_op_valid <= do_write && (reg_sel == `SCC_SEL_CACHE); // RL6 RL21
      tlb_op_valid <= do_write && (reg_sel == `SCC_SEL_TLB); // RL6
      rbuf_op_valid <= do_write && (reg_sel == `SCC_SEL_RBUF); // RL6
      test_op_valid <= do_write && (reg_sel == `SCC_SEL_TEST); // RL6
      if (do_write) begin
        maint_op <= op_field;
        maint_subop <= subop_field;
        maint_data <= wr_data;
      end
    end
  end

endmodule // scc_coproc

`default_nettype wire

// ==== verif/scc_coproc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_coproc_monitor (
  input wire sys_clk,
  input wire resetn,
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire core_priv,
  input wire instr_ready,
  input wire xfer_done,
  input wire undef_trap,
  input wire [31:0] rd_data,
  input wire high_vectors,
  input wire [31:0] vector_base,
  input wire [31:0] table_base,
  input wire user_rbuf_enable,
  input wire cache_op_valid
);
  wire take = instr_valid && instr_ready && instr_word[27:24] == 4'hE
    && instr_word[11:8] == 4'hF && instr_word[4];
  wire wr = take && !instr_word[20];
  wire rd = take && instr_word[20] && core_priv;
  wire [3:0] sel = instr_word[19:16];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_priv; take && core_priv |=> xfer_done && !undef_trap; endproperty
  a_priv: assert property (p_priv) else $error("privileged access not done");
  property p_user; take && !core_priv && !(wr && sel == 4'h9 && user_rbuf_enable)
    |=> undef_trap && !xfer_done; endproperty
  a_user: assert property (p_user) else $error("user access not trapped");
  property p_keep; undef_trap |-> $stable(rd_data) && $stable(table_base); endproperty
  a_keep: assert property (p_keep) else $error("trapped access changed state");
  property p_drain; wr && !core_priv && sel == 4'h7 |=> undef_trap; endproperty
  a_drain: assert property (p_drain) else $error("user drain not trapped");
  property p_fix; rd && sel == 4'h1 |=> rd_data[6:4] == 3'h7; endproperty
  a_fix: assert property (p_fix) else $error("control fixed bits wrong");
  property p_tb; rd && sel == 4'h2 |=> rd_data == table_base; endproperty
  a_tb: assert property (p_tb) else $error("table base read wrong");
  property p_low; table_base[13:0] == 14'h0; endproperty
  a_low: assert property (p_low) else $error("table base low bits set");
  property p_vec; vector_base == (high_vectors ? 32'hFFFF0000 : 32'h0); endproperty
  a_vec: assert property (p_vec) else $error("vector base wrong");
  property p_rbon; wr && core_priv && sel == 4'h9 && instr_word[7:5] == 3'h5
    && instr_word[3:0] == 4'h0 |=> user_rbuf_enable; endproperty
  a_rbon: assert property (p_rbon) else $error("user read buffer not enabled");
  property p_cop; wr && core_priv && sel == 4'h7 |=> cache_op_valid; endproperty
  a_cop: assert property (p_cop) else $error("cache op not strobed");
endmodule // scc_coproc_monitor
bind scc_coproc scc_coproc_monitor i_mon (.sys_clk(sys_clk), .resetn(resetn),
  .instr_valid(instr_valid), .instr_word(instr_word), .core_priv(core_priv),
  .instr_ready(instr_ready), .xfer_done(xfer_done), .undef_trap(undef_trap),
  .rd_data(rd_data), .high_vectors(high_vectors), .vector_base(vector_base),
  .table_base(table_base), .user_rbuf_enable(user_rbuf_enable),
  .cache_op_valid(cache_op_valid));
`default_nettype wire

// ==== verif/scc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_core_model (
  input wire sys_clk,
  input wire instr_ready,
  input wire xfer_done,
  input wire undef_trap,
  input wire [31:0] rd_data,
  output logic instr_valid,
  output logic [31:0] instr_word,
  output logic core_priv,
  output logic [31:0] wr_data
);
  initial begin
    instr_valid = 1'h0;
    instr_word = 32'h0;
    core_priv = 1'h1;
    wr_data = 32'h0;
  end
  // request held until a ready edge; released lines show inverted data, not stale
  task automatic xfer(input logic dir, input logic [3:0] sel, input logic [2:0] op,
      input logic [3:0] sub, input logic prv, input logic [31:0] d,
      output logic done, output logic trap, output logic [31:0] rv, output logic to);
    int n;
    n = 0;
    @(negedge sys_clk);
    instr_word = {8'hEE, 3'h0, dir, sel, 4'h3, 4'hF, op, 1'h1, sub};
    core_priv = prv;
    wr_data = d;
    instr_valid = 1'h1;
    while (!instr_ready && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    to = (n == 20);
    @(negedge sys_clk);
    done = xfer_done;
    trap = undef_trap;
    rv = rd_data;
    instr_valid = 1'h0;
    instr_word = ~instr_word;
    wr_data = ~wr_data;
  endtask
endmodule // scc_core_model
`default_nettype wire

// ==== verif/scc_coproc_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_coproc_test;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  wire instr_valid, core_priv, instr_ready, xfer_done, undef_trap;
  wire mmu_enable, align_fault_enable, dcache_enable, wbuf_enable, big_endian, sys_protect;
  wire rom_protect, icache_enable, high_vectors, user_rbuf_enable;
  wire cache_op_valid, tlb_op_valid, rbuf_op_valid, test_op_valid;
  wire [2:0] maint_op;
  wire [3:0] rd_core_reg, maint_subop;
  wire [31:0] instr_word, wr_data, rd_data, vector_base, table_base, process_tag;
  wire [31:0] breakpoint_cfg, maint_data;
  int err_total = 0;
  int n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  scc_coproc i_dut (.sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .core_priv(core_priv), .wr_data(wr_data),
    .instr_ready(instr_ready), .xfer_done(xfer_done), .undef_trap(undef_trap),
    .rd_data(rd_data), .rd_core_reg(rd_core_reg), .mmu_enable(mmu_enable),
    .align_fault_enable(align_fault_enable), .dcache_enable(dcache_enable),
    .wbuf_enable(wbuf_enable), .big_endian(big_endian), .sys_protect(sys_protect),
    .rom_protect(rom_protect), .icache_enable(icache_enable), .high_vectors(high_vectors),
    .vector_base(vector_base), .table_base(table_base), .process_tag(process_tag),
    .breakpoint_cfg(breakpoint_cfg), .user_rbuf_enable(user_rbuf_enable),
    .cache_op_valid(cache_op_valid), .tlb_op_valid(tlb_op_valid),
    .rbuf_op_valid(rbuf_op_valid), .test_op_valid(test_op_valid), .maint_op(maint_op),
    .maint_subop(maint_subop), .maint_data(maint_data));
  scc_core_model i_core (.sys_clk(sys_clk), .instr_ready(instr_ready),
    .xfer_done(xfer_done), .undef_trap(undef_trap), .rd_data(rd_data),
    .instr_valid(instr_valid), .instr_word(instr_word), .core_priv(core_priv),
    .wr_data(wr_data));
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic dir, input logic [3:0] sel, input logic [2:0] op,
      input logic [3:0] sub, input logic prv, input logic [31:0] d, input logic ok,
      input logic [31:0] exp);
    logic dn, tr, to;
    logic [31:0] rv;
    i_core.xfer(dir, sel, op, sub, prv, d, dn, tr, rv, to);
    if (to) begin
      err_total++;
      finish_test;
    end else begin
      chk({30'h0, dn, tr}, {30'h0, ok, !ok});
      if (dir && ok)
        chk(rv, exp);
    end
  endtask
  function automatic logic [31:0] outs();
    return {22'h0, align_fault_enable, dcache_enable, wbuf_enable, sys_protect, rom_protect,
      mmu_enable, big_endian, icache_enable, high_vectors, user_rbuf_enable};
  endfunction
  // strobes are still high at the negedge where a transfer call returns
  function automatic logic [31:0] ops();
    return {17'h0, rd_core_reg, cache_op_valid, tlb_op_valid, rbuf_op_valid, test_op_valid,
      maint_op, maint_subop};
  endfunction
  initial begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'h1;
    chk(outs(), 32'h0);
    chk(ops(), 32'h0);
    acc(1'h1, 4'h0, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h5A023C72);
    acc(1'h1, 4'h1, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h00000070);
    acc(1'h0, 4'h1, 3'h0, 4'h0, 1'h0, 32'hFFFFFFFF, 1'h0, 32'h0);
    acc(1'h1, 4'h1, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h00000070);
    acc(1'h0, 4'h1, 3'h0, 4'h0, 1'h1, 32'hFFFFFFFF, 1'h1, 32'h0);
    chk(outs(), 32'h000003FE);
    chk(vector_base, 32'hFFFF0000);
    acc(1'h1, 4'h1, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h000033FF);
    acc(1'h0, 4'h1, 3'h0, 4'h0, 1'h1, 32'h00000070, 1'h1, 32'h0);
    chk(outs(), 32'h0);
    acc(1'h0, 4'h2, 3'h0, 4'h0, 1'h1, 32'hFFFFFFFF, 1'h1, 32'h0);
    chk(table_base, 32'hFFFFC000);
    acc(1'h1, 4'h2, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'hFFFFC000);
    acc(1'h0, 4'h0, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h0);
    acc(1'h1, 4'h0, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h5A023C72);
    acc(1'h1, 4'h7, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h0);
    acc(1'h1, 4'h4, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h0);
    acc(1'h0, 4'hD, 3'h0, 4'h0, 1'h1, 32'h12345678, 1'h1, 32'h0);
    chk(process_tag, 32'h12345678);
    acc(1'h0, 4'hE, 3'h0, 4'h0, 1'h1, 32'h9ABCDEF0, 1'h1, 32'h0);
    chk(breakpoint_cfg, 32'h9ABCDEF0);
    acc(1'h1, 4'hD, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h12345678);
    acc(1'h1, 4'hE, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h9ABCDEF0);
    acc(1'h0, 4'h7, 3'h4, 4'hA, 1'h1, 32'h0, 1'h1, 32'h0);
    chk(ops(), 32'h00001C4A);
    acc(1'h0, 4'h8, 3'h1, 4'h6, 1'h1, 32'h0000A5C0, 1'h1, 32'h0);
    chk(ops(), 32'h00001A16);
    chk(maint_data, 32'h0000A5C0);
    acc(1'h0, 4'hF, 3'h2, 4'h1, 1'h1, 32'h0, 1'h1, 32'h0);
    chk(ops(), 32'h000018A1);
    acc(1'h0, 4'h9, 3'h2, 4'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    acc(1'h0, 4'h9, 3'h5, 4'h0, 1'h1, 32'h0, 1'h1, 32'h0);
    chk(outs(), 32'h00000001);
    chk(ops(), 32'h00001950);
    acc(1'h0, 4'h9, 3'h2, 4'h0, 1'h0, 32'h00000100, 1'h1, 32'h0);
    acc(1'h0, 4'h7, 3'h4, 4'hA, 1'h0, 32'h0, 1'h0, 32'h0);
    chk(ops(), 32'h00001820);
    chk(maint_data, 32'h00000100);
    acc(1'h1, 4'h9, 3'h0, 4'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    acc(1'h0, 4'h9, 3'h4, 4'h0, 1'h1, 32'h0, 1'h1, 32'h0);
    acc(1'h0, 4'h9, 3'h2, 4'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    // mid-run reset with every control bit set, so clearing is really seen
    acc(1'h0, 4'h1, 3'h0, 4'h0, 1'h1, 32'hFFFFFFFF, 1'h1, 32'h0);
    @(negedge sys_clk);
    resetn = 1'h0;
    @(negedge sys_clk);
    chk(outs(), 32'h0);
    resetn = 1'h1;
    acc(1'h1, 4'h1, 3'h0, 4'h0, 1'h1, 32'h0, 1'h1, 32'h00000070);
    finish_test;
  end
endmodule // scc_coproc_test
`default_nettype wire
